// [rtl/acq_interrupt_timer_dma_req.v]
// Purpose: interrupt flags, limit flags, delay timer and DMA request
// Assumes: sequencer, fifo and converter events arrive as same-clock pulses
// Notes: bus strobes, address and data come from pins and are
//        synchronised through two flops before any logic reads them
`timescale 1ns/1ps
`include "acq_irq_defs.vh"
module acq_interrupt_timer_dma_req (
   // Clock and reset
   input wire i_clock,
   input wire i_rst_n,
   // Parallel bus pins
   input wire i_rd_n,
   input wire i_wr_n,
   input wire i_cs_n,
   input wire i_bus_width_select,
   input wire [4:0] i_addr,
   input wire [15:0] i_wdata,
   output reg [15:0] o_rdata,
   // Device reset and sequencer state
   input wire i_dev_reset,
   input wire i_seq_start,
   input wire i_seq_running,
   input wire [2:0] i_seq_pointer,
   input wire i_fetch,
   input wire i_timer_start,
   output reg o_delay_wait_state,
   // Events from the converter and fifo
   input wire [4:0] i_fifo_count,
   input wire i_az_done,
   input wire i_cal_done,
   input wire i_pause_hit,
   input wire i_standby_done,
   input wire i_lim1_hit,
   input wire i_lim2_hit,
   input wire [2:0] i_lim_instr,
   // Host signals
   output reg o_int_n,
   output reg o_fifo_transfer_request
);

// ==========================================================
// Pin synchronisers
reg [1:0] rd_sync_r;
reg [1:0] wr_sync_r;
reg [1:0] cs_sync_r;
reg [1:0] bw_sync_r;
reg rd_q_r;
reg wr_q_r;
wire rd_act = ~rd_sync_r[1] & ~cs_sync_r[1];
wire wr_act = ~wr_sync_r[1] & ~cs_sync_r[1];
wire rd_fall = rd_act & ~rd_q_r;
wire wr_fall = wr_act & ~wr_q_r;
wire bw8 = bw_sync_r[1];

// Two flops per strobe; address and data are stable while strobes are low
// Strobe stages reset to the idle high level: a low reset value would
// look like a strobe fall at the first edge and fake a host access
always @(posedge i_clock or negedge i_rst_n) begin
   if (!i_rst_n) begin
      rd_sync_r <= 2'h3;
      wr_sync_r <= 2'h3;
      cs_sync_r <= 2'h3;
      bw_sync_r <= 2'h0;
      rd_q_r <= 1'b0;
      wr_q_r <= 1'b0;
   end else begin
      rd_sync_r <= {rd_sync_r[0], i_rd_n};
      wr_sync_r <= {wr_sync_r[0], i_wr_n};
      cs_sync_r <= {cs_sync_r[0], i_cs_n};
      bw_sync_r <= {bw_sync_r[0], i_bus_width_select};
      rd_q_r <= rd_act;
      wr_q_r <= wr_act;
   end
end

// ==========================================================
// Address and data synchronisers
// Two stages, the same depth as the strobes, so the decoded word lines
// up with the synchronised strobe edge. The host must hold address and
// data for the whole strobe; a shorter strobe may decode a stale word.
reg [4:0] addr_s1_r;
reg [4:0] addr_s2_r;
reg [15:0] wdata_s1_r;
reg [15:0] wdata_s2_r;

// Plain two-flop pipes; only the second stage feeds the decode
always @(posedge i_clock or negedge i_rst_n) begin
   if (!i_rst_n) begin
      addr_s1_r <= 5'h00;
      addr_s2_r <= 5'h00;
      wdata_s1_r <= 16'h0000;
      wdata_s2_r <= 16'h0000;
   end else begin
      addr_s1_r <= i_addr;
      addr_s2_r <= addr_s1_r;
      wdata_s1_r <= i_wdata;
      wdata_s2_r <= wdata_s1_r;
   end
end

// ==========================================================
// Address decode
reg [3:0] word_addr;
reg hi_byte;
// Word select from A4..A1 either way; A0 picks the byte on the 8-bit bus
always @* begin
   word_addr = addr_s2_r[4:1];
   hi_byte = bw8 & addr_s2_r[0];
end

wire sel_mask = (word_addr == `ADDR_MASK);
wire sel_flags = (word_addr == `ADDR_FLAGS);
wire sel_preset = (word_addr == `ADDR_PRESET);
wire sel_limit = (word_addr == `ADDR_LIMIT);
// Flags clear on the high byte read in 8-bit mode so both halves match
wire flags_rd = rd_fall & sel_flags & (~bw8 | hi_byte);
wire limit_rd = rd_fall & sel_limit & (~bw8 | hi_byte);

// ==========================================================
// Writable registers
reg [15:0] mask_r;
reg [15:0] preset_r;

// Byte lane writes on the 8-bit bus, whole word otherwise
// A write lands once per strobe, on the synchronised falling edge only,
// so a long strobe never repeats it
always @(posedge i_clock or negedge i_rst_n) begin
   if (!i_rst_n) begin
      mask_r <= `MASK_RST;
      preset_r <= `PRESET_RST;
   end else if (wr_fall) begin
      if (sel_mask) begin
         if (!bw8)
            mask_r <= wdata_s2_r;
         else if (hi_byte)
            mask_r[15:8] <= wdata_s2_r[7:0];
         else
            mask_r[7:0] <= wdata_s2_r[7:0];
      end else if (sel_preset) begin
         if (!bw8)
            preset_r <= wdata_s2_r;
         else if (hi_byte)
            preset_r[15:8] <= wdata_s2_r[7:0];
         else
            preset_r[7:0] <= wdata_s2_r[7:0];
      end
   end
end

wire [2:0] match_addr = mask_r[`MATCH_HI:`MATCH_LO];
wire [4:0] fifo_thr = mask_r[`THR_HI:`THR_LO];

// ==========================================================
// Event detection
reg seen_zero_r;
reg [4:0] count_q_r;
wire fifo_thr_hit = (i_fifo_count == fifo_thr) & (count_q_r != fifo_thr);
// Zero address waits for a second pass of instruction zero after start
wire match_hit = i_fetch & (i_seq_pointer == match_addr) &
   ((match_addr != 3'h0) | seen_zero_r);

// Remember the first fetch of instruction zero since start
always @(posedge i_clock or negedge i_rst_n) begin
   if (!i_rst_n) begin
      seen_zero_r <= 1'b0;
      count_q_r <= `FIFO_EMPTY;
   end else begin
      count_q_r <= i_fifo_count;
      if (i_dev_reset | ~i_seq_start)
         seen_zero_r <= 1'b0;
      else if (i_fetch & (i_seq_pointer == 3'h0))
         seen_zero_r <= 1'b1;
   end
end

wire [7:0] ev;
assign ev[`BIT_LIMIT] = i_lim1_hit | i_lim2_hit;
assign ev[`BIT_MATCH] = match_hit;
assign ev[`BIT_FIFO] = fifo_thr_hit;
assign ev[`BIT_AZ] = i_az_done;
assign ev[`BIT_CAL] = i_cal_done;
assign ev[`BIT_PAUSE] = i_pause_hit;
assign ev[`BIT_UNUSED] = 1'b0;
assign ev[`BIT_STBY] = i_standby_done;

// ==========================================================
// Sticky status and limit flags
reg [7:0] flags_r;
reg [15:0] limit_r;
wire [15:0] lim_ev;

// One set term per limit bit; set wins over a same-cycle read clear
genvar g;
generate
   for (g = 0; g < 8; g = g + 1) begin : g_lim
      assign lim_ev[g] = i_lim1_hit & (i_lim_instr == g);
      assign lim_ev[g + `LIM2_BASE] = i_lim2_hit & (i_lim_instr == g);
   end
endgenerate

// Flags set regardless of mask; read or device reset clears them
always @(posedge i_clock or negedge i_rst_n) begin
   if (!i_rst_n) begin
      flags_r <= 8'h00;
      limit_r <= 16'h0000;
   end else if (i_dev_reset) begin
      flags_r <= 8'h00;
      limit_r <= 16'h0000;
   end else begin
      flags_r <= (flags_r & {8{~flags_rd}}) | ev;
      limit_r <= (limit_r & {16{~limit_rd}}) | lim_ev;
   end
end

// ==========================================================
// Interrupt pin and DMA request
// Next flag value is used so the pin and request move in the event cycle
wire [7:0] flags_nxt = i_dev_reset ? 8'h00 :
   ((flags_r & {8{~flags_rd}}) | ev);
wire [7:0] live = flags_nxt & mask_r[7:0];
wire dma_en = mask_r[`BIT_FIFO];
reg dma_arm_r;

// Request rises at the threshold hit, falls when the fifo drains
always @(posedge i_clock or negedge i_rst_n) begin
   if (!i_rst_n) begin
      o_int_n <= 1'b1;
      o_fifo_transfer_request <= 1'b0;
      dma_arm_r <= 1'b1;
   end else begin
      o_int_n <= ~(|live);
      if (i_dev_reset | ~dma_en) begin
         o_fifo_transfer_request <= 1'b0;
         dma_arm_r <= 1'b1;
      end else if (fifo_thr_hit & dma_arm_r) begin
         o_fifo_transfer_request <= 1'b1;
         dma_arm_r <= 1'b0;
      end else begin
         if (i_fifo_count == `FIFO_EMPTY)
            o_fifo_transfer_request <= 1'b0;
         if (flags_rd)
            dma_arm_r <= 1'b1;
      end
   end
end

// ==========================================================
// Delay timer
reg [4:0] presc_r;
reg [15:0] tcount_r;
reg [1:0] tail_r;
localparam ST_IDLE = 3'b001;
localparam ST_COUNT = 3'b010;
localparam ST_TAIL = 3'b100;
reg [2:0] tstate_r;

// Runs 32 prescaled ticks per count, then two tail clocks; never
// touched by interrupt flags, so events cannot stall the sequence
// Only a device reset ends a delay early; flag reads and mask writes
// leave it running
always @(posedge i_clock or negedge i_rst_n) begin
   if (!i_rst_n) begin
      tstate_r <= ST_IDLE;
      presc_r <= 5'h00;
      tcount_r <= 16'h0000;
      tail_r <= 2'h0;
      o_delay_wait_state <= 1'b0;
   end else if (i_dev_reset) begin
      tstate_r <= ST_IDLE;
      o_delay_wait_state <= 1'b0;
   end else begin
      case (tstate_r)
         ST_IDLE: begin
            if (i_timer_start) begin
               tcount_r <= preset_r;
               presc_r <= 5'h00;
               tail_r <= 2'h0;
               o_delay_wait_state <= 1'b1;
               tstate_r <= (preset_r == 16'h0000) ? ST_TAIL : ST_COUNT;
            end
         end
         ST_COUNT: begin
            presc_r <= presc_r + 5'h01;
            if (presc_r == `PRESCALE_TOP) begin
               tcount_r <= tcount_r - 16'h0001;
               if (tcount_r == 16'h0001)
                  tstate_r <= ST_TAIL;
            end
         end
         ST_TAIL: begin
            tail_r <= tail_r + 2'h1;
            if (tail_r == `TIMER_EXTRA - 2'h1) begin
               o_delay_wait_state <= 1'b0;
               tstate_r <= ST_IDLE;
            end
         end
         default: tstate_r <= ST_IDLE;
      endcase
   end
end

// ==========================================================
// Read data
reg [15:0] word;
// Live pointer and count only while running; unmapped reads give zero
always @* begin
   word = 16'h0000;
   if (sel_mask)
      word = mask_r;
   else if (sel_flags) begin
      word[7:0] = flags_r;
      if (i_seq_running) begin
         word[`MATCH_HI:`MATCH_LO] = i_seq_pointer;
         word[`THR_HI:`THR_LO] = i_fifo_count;
      end
   end else if (sel_preset)
      word = preset_r;
   else if (sel_limit)
      word = limit_r;
end

// Read data register, byte steered to low lane on the 8-bit bus
// Captured at the read take, the same edge that clears the flags, so
// the host sees the flags as they stood before the clear
always @(posedge i_clock or negedge i_rst_n) begin
   if (!i_rst_n)
      o_rdata <= 16'h0000;
   else if (rd_act & ~rd_q_r)
      o_rdata <= hi_byte ? {8'h00, word[15:8]} : word;
end

endmodule // acq_interrupt_timer_dma_req

// [include/acq_irq_defs.vh]
// Purpose: constants for the acquisition interrupt, limit, timer and DMA block
// Assumes: 10 MHz clock, register map reached through the parallel bus pins
// Notes: all offsets are word addresses on A4..A1
`ifndef ACQ_IRQ_DEFS_VH
`define ACQ_IRQ_DEFS_VH
// ==========================================================
// Register word addresses
`define ADDR_MASK 4'h9
`define ADDR_FLAGS 4'ha
`define ADDR_PRESET 4'hb
`define ADDR_LIMIT 4'hd
// ==========================================================
// Field positions
`define BIT_LIMIT 0
`define BIT_MATCH 1
`define BIT_FIFO 2
`define BIT_AZ 3
`define BIT_CAL 4
`define BIT_PAUSE 5
`define BIT_UNUSED 6
`define BIT_STBY 7
`define MATCH_LO 8
`define MATCH_HI 10
`define THR_LO 11
`define THR_HI 15
`define LIM2_BASE 8
// ==========================================================
// Reset values and timing
`define MASK_RST 16'h0000
`define PRESET_RST 16'h0000
`define PRESCALE_TOP 5'h1f
`define TIMER_EXTRA 2'h2
`define FIFO_EMPTY 5'h00
`endif

// [verif/acq_irq_checker.sv]
// Purpose: port-level checks for the interrupt, timer and DMA block
// Assumes: one clock, asynchronous active-low reset
// Notes: host accesses are judged only after the strobes rest a while
`timescale 1ns/1ps
module acq_irq_checker (
   // Clock and reset
   input logic i_clock,
   input logic i_rst_n,
   // Watched inputs
   input logic i_rd_n,
   input logic i_wr_n,
   input logic i_dev_reset,
   input logic i_timer_start,
   input logic [4:0] i_fifo_count,
   // Watched outputs
   input logic [15:0] o_rdata,
   input logic o_int_n,
   input logic o_fifo_transfer_request,
   input logic o_delay_wait_state
);
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_rst_n);
   // ==========================================================
   // Quiet counter: strobes pass a 2-flop sync, so wait it out
   wire quiet = i_rd_n & i_wr_n;
   logic [2:0] quiet_cnt_r;
   always @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) quiet_cnt_r <= 3'h0;
      else if (!quiet) quiet_cnt_r <= 3'h0;
      else if (quiet_cnt_r != 3'h7) quiet_cnt_r <= quiet_cnt_r + 3'h1;
   end
   // ==========================================================
   // Assertions
   chk_int_holds_low: assert property (!o_int_n && quiet_cnt_r == 3'h7 &&
      !i_dev_reset |=> !o_int_n) else $error("interrupt released");
   chk_rdata_holds: assert property (quiet_cnt_r == 3'h7 |->
      $stable(o_rdata)) else $error("read data moved");
   chk_dma_with_int: assert property ($rose(o_fifo_transfer_request)
      |-> !o_int_n) else $error("dma request without interrupt");
   chk_dma_drop_empty: assert property (i_fifo_count == 5'h00 |=>
      !o_fifo_transfer_request) else $error("dma request on empty");
   chk_dma_stands: assert property (o_fifo_transfer_request &&
      i_fifo_count != 5'h00 && !i_dev_reset |=> o_fifo_transfer_request)
      else $error("dma request dropped early");
   chk_dev_reset_clear: assert property (i_dev_reset |=> o_int_n &&
      !o_fifo_transfer_request && !o_delay_wait_state)
      else $error("device reset left state");
   chk_wait_cause: assert property ($rose(o_delay_wait_state) |->
      $past(i_timer_start) || $past(i_timer_start, 2))
      else $error("delay without start");
   chk_wait_min_len: assert property ($rose(o_delay_wait_state) |->
      o_delay_wait_state[*2]) else $error("delay shorter than 2");
endmodule // acq_irq_checker

// [verif/acq_host_model.sv]
// Purpose: host processor on the parallel bus
// Assumes: strobes change at the falling clock edge
// Notes: released data lines show the inverse of the last value
`timescale 1ns/1ps
module acq_host_model (
   // Clock and read data
   input logic i_clock,
   input logic [15:0] i_rdata,
   // Bus pins
   output logic o_cs_n,
   output logic o_rd_n,
   output logic o_wr_n,
   output logic o_bus_width_select,
   output logic [4:0] o_addr,
   output logic [15:0] o_wdata
);
   // Idle bus at time zero
   initial begin
      o_cs_n = 1'b1;
      o_rd_n = 1'b1;
      o_wr_n = 1'b1;
      o_bus_width_select = 1'b0;
      o_addr = 5'h00;
      o_wdata = 16'h0000;
   end
   // One access; strobes held 4 cycles to clear the sync delay
   task automatic xfer(input [3:0] w, input b, input wr, input [15:0] d,
         output [15:0] q);
      @(negedge i_clock);
      o_addr = {w, b};
      o_wdata = d;
      o_cs_n = 1'b0;
      o_rd_n = wr;
      o_wr_n = !wr;
      repeat (4) @(negedge i_clock);
      q = i_rdata;
      o_cs_n = 1'b1;
      o_rd_n = 1'b1;
      o_wr_n = 1'b1;
      o_wdata = ~d;
      repeat (2) @(negedge i_clock);
   endtask
endmodule // acq_host_model

// [verif/acq_interrupt_timer_dma_req_bench.sv]
// Purpose: self-checking bench for the interrupt, timer and DMA block
// Assumes: 10 MHz clock, inputs driven at the falling edge
// Notes: timer preset kept small so the delay stays short
`timescale 1ns/1ps
`include "acq_irq_defs.vh"
module acq_interrupt_timer_dma_req_bench;
   logic i_clock, i_rst_n, i_dev_reset, i_seq_start, i_seq_running, i_fetch;
   logic i_timer_start, i_az_done, i_cal_done, i_pause_hit, i_standby_done;
   logic i_lim1_hit, i_lim2_hit, i_rd_n, i_wr_n, i_cs_n, i_bus_width_select;
   logic [2:0] i_seq_pointer, i_lim_instr;
   logic [4:0] i_fifo_count, i_addr;
   logic [15:0] i_wdata, o_rdata, q;
   logic o_int_n, o_fifo_transfer_request, o_delay_wait_state;
   int mismatches, compares, n;
   acq_interrupt_timer_dma_req uut (.i_clock, .i_rst_n, .i_rd_n, .i_wr_n,
      .i_cs_n, .i_bus_width_select, .i_addr, .i_wdata, .o_rdata, .i_dev_reset,
      .i_seq_start, .i_seq_running, .i_seq_pointer, .i_fetch, .i_timer_start,
      .o_delay_wait_state, .i_fifo_count, .i_az_done, .i_cal_done,
      .i_pause_hit, .i_standby_done, .i_lim1_hit, .i_lim2_hit, .i_lim_instr,
      .o_int_n, .o_fifo_transfer_request);
   acq_host_model h (.i_clock, .i_rdata(o_rdata), .o_cs_n(i_cs_n),
      .o_rd_n(i_rd_n), .o_wr_n(i_wr_n), .o_addr(i_addr), .o_wdata(i_wdata),
      .o_bus_width_select(i_bus_width_select));
   // ==========================================================
   // Helpers
   task chk(input string nm, input [15:0] e, input [15:0] g);
      compares++;
      if (g !== e) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task rw(input [3:0] w, input [15:0] d);
      h.xfer(w, 1'b0, 1'b1, d, q);
   endtask
   task rc(input string nm, input [3:0] w, input [15:0] e);
      h.xfer(w, 1'b0, 1'b0, 16'h0000, q);
      chk(nm, e, q);
   endtask
   // Pulse events for one cycle: az, cal, pause, standby, lim1, lim2
   task ev(input [5:0] v);
      @(negedge i_clock);
      {i_az_done, i_cal_done, i_pause_hit, i_standby_done} = v[5:2];
      {i_lim1_hit, i_lim2_hit} = v[1:0];
      @(negedge i_clock);
      {i_az_done, i_cal_done, i_pause_hit, i_standby_done} = 4'h0;
      {i_lim1_hit, i_lim2_hit} = 2'h0;
      @(negedge i_clock);
   endtask
   task fetch;
      @(negedge i_clock) i_fetch = 1'b1;
      @(negedge i_clock) i_fetch = 1'b0;
      @(negedge i_clock);
   endtask
   // ==========================================================
   // Scenarios
   task t_events;
      rc("unmapped", 4'h3, 16'h0000);
      rc("mask", `ADDR_MASK, `MASK_RST);
      i_lim_instr = 3'h3;
      ev(6'h02);
      i_lim_instr = 3'h6;
      ev(6'h01);
      ev(6'h3c);
      chk("int masked", 16'h0001, o_int_n);
      rc("flags", `ADDR_FLAGS, 16'h00b9);
      rc("limit", `ADDR_LIMIT, 16'h4008);
      rc("flags clr", `ADDR_FLAGS, 16'h0000);
      rc("limit clr", `ADDR_LIMIT, 16'h0000);
   endtask
   task t_mask;
      rw(`ADDR_MASK, 16'h0010);
      rc("flags discard", `ADDR_FLAGS, 16'h0000);
      ev(6'h10);
      chk("int on", 16'h0000, o_int_n);
      rc("flags cal", `ADDR_FLAGS, 16'h0010);
      chk("int off", 16'h0001, o_int_n);
   endtask
   task t_match;
      rw(`ADDR_MASK, 16'h0002);
      rc("flags discard", `ADDR_FLAGS, 16'h0000);
      i_seq_start = 1'b1;
      fetch();
      chk("first fetch", 16'h0001, o_int_n);
      fetch();
      chk("second fetch", 16'h0000, o_int_n);
      rc("flags match", `ADDR_FLAGS, 16'h0002);
      i_seq_start = 1'b0;
   endtask
   task t_fifo;
      rw(`ADDR_MASK, 16'h1804);
      rc("flags discard", `ADDR_FLAGS, 16'h0000);
      i_seq_running = 1'b1;
      i_seq_pointer = 3'h5;
      for (n = 1; n <= 3; n++) @(negedge i_clock) i_fifo_count = n[4:0];
      repeat (8) @(negedge i_clock);
      chk("dma up", 16'h0001, o_fifo_transfer_request);
      chk("int with dma", 16'h0000, o_int_n);
      rc("flags run", `ADDR_FLAGS, 16'h1d04);
      i_fifo_count = 5'h00;
      repeat (2) @(negedge i_clock);
      chk("dma down", 16'h0000, o_fifo_transfer_request);
      i_seq_running = 1'b0;
   endtask
   task t_timer;
      h.o_bus_width_select = 1'b1;
      repeat (3) @(negedge i_clock);
      h.xfer(`ADDR_PRESET, 1'b0, 1'b1, 16'h0002, q);
      h.xfer(`ADDR_PRESET, 1'b1, 1'b1, 16'h0000, q);
      h.xfer(`ADDR_PRESET, 1'b0, 1'b0, 16'h0000, q);
      chk("preset low", 16'h0002, q[7:0]);
      h.o_bus_width_select = 1'b0;
      @(negedge i_clock) i_timer_start = 1'b1;
      @(negedge i_clock) i_timer_start = 1'b0;
      n = 0;
      repeat (3) if (o_delay_wait_state !== 1'b1) @(negedge i_clock);
      while (o_delay_wait_state === 1'b1 && n < 300) begin
         n++;
         @(negedge i_clock);
      end
      chk("delay len", 16'h0042, n[15:0]);
   endtask
   task t_devreset;
      ev(6'h08);
      @(negedge i_clock) i_dev_reset = 1'b1;
      @(negedge i_clock) i_dev_reset = 1'b0;
      rc("flags reset", `ADDR_FLAGS, 16'h0000);
   endtask
   // ==========================================================
   // Verdict
   task final_report;
      $display("mismatches=%0d compares=%0d", mismatches, compares);
      if (mismatches == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // Clock
   initial begin
      i_clock = 1'b0;
      forever #50 i_clock = ~i_clock;
   end
   // Watchdog, far beyond the expected few hundred cycles
   initial begin
      #2000000;
      mismatches++;
      final_report();
   end
   // Main sequence
   initial begin
      {i_rst_n, i_dev_reset, i_seq_start, i_seq_running, i_fetch} = 5'h00;
      {i_timer_start, i_az_done, i_cal_done, i_pause_hit} = 4'h0;
      {i_standby_done, i_lim1_hit, i_lim2_hit} = 3'h0;
      i_seq_pointer = 3'h0;
      i_lim_instr = 3'h0;
      i_fifo_count = 5'h00;
      mismatches = 0;
      compares = 0;
      repeat (2) @(negedge i_clock);
      i_rst_n = 1'b1;
      repeat (3) @(negedge i_clock);
      t_events();
      t_mask();
      t_match();
      t_fifo();
      t_timer();
      t_devreset();
      final_report();
   end
endmodule // acq_interrupt_timer_dma_req_bench
bind acq_interrupt_timer_dma_req acq_irq_checker chk (.i_clock, .i_rst_n,
   .i_rd_n, .i_wr_n, .i_dev_reset, .i_timer_start, .i_fifo_count, .o_rdata,
   .o_int_n, .o_fifo_transfer_request, .o_delay_wait_state);
